// File: src/nsp_host.sv
// host controller that drives nand command, address and data cycles
// assumes software issues one strobe per request and polls busy_op
`timescale 1ns/1ps
`default_nettype none
module nsp_host
  import nsp_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_ce_n,
  output logic            o_cle,
  output logic            o_ale,
  output logic            o_we_n,
  output logic            o_read_strobe_n,
  output logic            o_wp_n,
  output logic      [7:0] o_io_out,
  output logic            o_io_oe,
  input  wire logic [7:0] i_io_in,
  input  wire logic       i_ready_busy_n
);
  nsp_state_e st_q;
  nsp_state_e st_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] io_q;
  logic [7:0] io_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] last_q;
  logic [7:0] last_d;
  // kind: 0 command, 1 address, 2 data byte
  logic [1:0] kind_q;
  logic [1:0] kind_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       ce_n_q;
  logic       ce_n_d;
  logic       cle_q;
  logic       cle_d;
  logic       ale_q;
  logic       ale_d;
  logic       we_n_q;
  logic       we_n_d;
  logic       re_n_q;
  logic       re_n_d;
  logic       oe_q;
  logic       oe_d;
  logic       stat_mode_q;
  logic       stat_mode_d;
  logic [7:0] io_s1_q;
  logic [7:0] io_s2_q;
  logic [1:0] rb_s_q;
  logic [2:0] owed_q;
  logic [2:0] owed_d;
  logic       cmd_take;

  // pins come from outside the clock domain
  // the io byte is held by the flash for the whole low strobe, so
  // its bits settle long before the sampling cycle reads them
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      io_s1_q <= 8'h00;
      io_s2_q <= 8'h00;
      rb_s_q  <= 2'b00;
    end
    else
    begin
      io_s1_q <= i_io_in;
      io_s2_q <= io_s1_q;
      rb_s_q  <= {rb_s_q[0], i_ready_busy_n};
    end
  end

  // commands other than status/reset are held off while busy
  function automatic logic nsp_cmd_ok(input logic [7:0] c,
                                      input logic rdy);
    nsp_cmd_ok = rdy || c == NSP_CMD_STATUS ||
                 c == NSP_CMD_STATUS_ENH || c == NSP_CMD_RESET; // [RQ20]
  endfunction

  // busy while any pin cycle is in flight
  logic busy_op;
  assign busy_op = (st_q != NSP_IDLE);

  // address cycles that each command code opens
  function automatic logic [2:0] nsp_addr_need(input logic [7:0] c);
    nsp_addr_need = 3'h0;
    if (c == NSP_CMD_DATA_IN)
      nsp_addr_need = NSP_ADDR_PROG; // [RQ19]
    else if (c == NSP_CMD_RAND_IN)
      nsp_addr_need = NSP_ADDR_COL; // [RQ21]
    else if (c == NSP_CMD_STATUS_ENH)
      nsp_addr_need = NSP_ADDR_ROW; // [RQ10]
    // other codes open no address phase
  endfunction

  // a command accepted this cycle, as the state machine sees it
  assign cmd_take = (st_q == NSP_IDLE) && i_wr && (i_addr == NSP_A_CMD) &&
                    nsp_cmd_ok(i_wdata, rb_s_q[1]);

  // one pin cycle at a time; requests while busy are dropped
  always_comb
  begin
    st_d = st_q;
    ctrl_d = ctrl_q;
    io_d = io_q;
    rdata_d = rdata_q;
    last_d = last_q;
    kind_d = kind_q;
    cnt_d = cnt_q;
    ce_n_d = ce_n_q;
    cle_d = 1'b0;
    ale_d = 1'b0;
    we_n_d = 1'b1;
    re_n_d = 1'b1;
    oe_d = 1'b0;
    stat_mode_d = stat_mode_q;
    case (st_q)
      NSP_IDLE:
      begin
        ce_n_d = ~ctrl_q[0];
        cnt_d = 2'd0;
        if (i_wr && i_addr == NSP_A_CTRL)
          ctrl_d = i_wdata;
        else if (i_wr && i_addr == NSP_A_CMD)
        begin
          // page order, partial counts, plane choice, otp use and id
          // checks are sequenced by software through this path
          // [RQ13] [RQ14] [RQ16] [RQ17] [RQ18]
          if (nsp_cmd_ok(i_wdata, rb_s_q[1]))
          begin
            st_d = NSP_WLOW;
            kind_d = 2'd0;
            io_d = i_wdata;
            last_d = i_wdata;
            // status stays selected until next command
            stat_mode_d = (i_wdata == NSP_CMD_STATUS) ||
                          (i_wdata == NSP_CMD_STATUS_ENH); // [RQ1] [RQ3] [RQ12]
          end
        end
        else if (i_wr && i_addr == NSP_A_ADDR)
        begin
          // row cycles after enhanced status use the same path [RQ10]
          st_d = NSP_WLOW;
          kind_d = 2'd1;
          io_d = i_wdata;
        end
        else if (i_wr && i_addr == NSP_A_WDATA)
        begin
          st_d = NSP_WLOW;
          kind_d = 2'd2;
          io_d = i_wdata; // one byte per write strobe [RQ19] [RQ21]
        end
        // a read of the data register starts a pin read cycle
        else if (i_rd && i_addr == NSP_A_RDATA)
          st_d = NSP_RLOW;
      end
      NSP_WLOW:
      begin
        // strobe low with the byte already on the bus
        ce_n_d = 1'b0;
        cle_d = (kind_q == 2'd0);
        ale_d = (kind_q == 2'd1);
        we_n_d = 1'b0;
        oe_d = 1'b1;
        cnt_d = cnt_q + 2'd1;
        if (cnt_q >= NSP_PHASE_MAX - 2'd1)
        begin
          st_d = NSP_WHIGH;
          cnt_d = 2'd0;
        end
      end
      NSP_WHIGH:
      begin
        // latch enables, select and data hold across the rising strobe
        ce_n_d = 1'b0;
        cle_d = (kind_q == 2'd0);
        ale_d = (kind_q == 2'd1);
        oe_d = 1'b1;
        st_d = NSP_IDLE;
      end
      NSP_RLOW:
      begin
        ce_n_d = 1'b0;
        re_n_d = 1'b0;
        cnt_d = cnt_q + 2'd1;
        // two sync stages plus one phase before sampling
        if (cnt_q == NSP_RD_LAST)
        begin
          rdata_d = io_s2_q; // status byte when in status mode [RQ2]
          st_d = NSP_IDLE;
          re_n_d = 1'b1;
        end
      end
      default: st_d = NSP_IDLE;
    endcase
  end

  // read data answers one cycle after the read strobe
  // reads are answered even while busy; writes and pin read starts are dropped
  logic [7:0] rd_word;
  always_comb
  begin
    rd_word = 8'h00;
    if (i_addr == NSP_A_CTRL)
      rd_word = ctrl_q;
    else if (i_addr == NSP_A_RDATA)
      rd_word = rdata_q;
    else if (i_addr == NSP_A_STATUS)
      rd_word = {4'h0, (owed_q != 3'h0), stat_mode_q, rb_s_q[1],
                 busy_op}; // [RQ7]
    else if (i_addr == NSP_A_LAST)
      rd_word = last_q;
  end

  logic [7:0] bus_q;
  logic [7:0] bus_d;
  always_comb
  begin
    bus_d = 8'h00;
    if (i_rd)
      bus_d = rd_word;
  end

  // address cycles still owed; software can see an unfinished sequence
  always_comb
  begin
    owed_d = owed_q;
    if (cmd_take)
      owed_d = nsp_addr_need(i_wdata);
    // surplus address writes leave the count at zero
    else if (st_q == NSP_IDLE && i_wr && i_addr == NSP_A_ADDR &&
             owed_q != 3'h0)
      owed_d = owed_q - 3'h1; // [RQ10] [RQ19] [RQ21]
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      owed_q <= 3'h0;
    else
      owed_q <= owed_d;
  end

  // registers only; all decisions live in the combinational blocks
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_q <= NSP_IDLE;
      ctrl_q <= NSP_RST_CTRL;
      io_q <= 8'h00;
      rdata_q <= 8'h00;
      last_q <= 8'h00;
      kind_q <= 2'd0;
      cnt_q <= 2'd0;
      ce_n_q <= 1'b1;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      we_n_q <= 1'b1;
      re_n_q <= 1'b1;
      oe_q <= 1'b0;
      stat_mode_q <= 1'b0;
      bus_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      ctrl_q <= ctrl_d;
      io_q <= io_d;
      rdata_q <= rdata_d;
      last_q <= last_d;
      kind_q <= kind_d;
      cnt_q <= cnt_d;
      ce_n_q <= ce_n_d;
      cle_q <= cle_d;
      ale_q <= ale_d;
      we_n_q <= we_n_d;
      re_n_q <= re_n_d;
      oe_q <= oe_d;
      stat_mode_q <= stat_mode_d;
      bus_q <= bus_d;
    end
  end

  // every pin is a flop so no glitch reaches the flash
  assign o_rdata = bus_q;
  assign o_ce_n = ce_n_q;
  assign o_cle = cle_q;
  assign o_ale = ale_q;
  assign o_we_n = we_n_q;
  assign o_read_strobe_n = re_n_q;
  assign o_wp_n = ctrl_q[1]; // write protect pin driven from control [RQ8]
  assign o_io_out = io_q;
  assign o_io_oe = oe_q;
endmodule
`default_nettype wire

// File: src/nsp_pkg.sv
// constants for the nand status/program host controller
// assumes one 20 MHz clock and an asynchronous flash pin interface
// Summary of operation
// RQ1 - after the status command, every read cycle returns the status byte
// RQ2 - status byte is valid while chip select and read strobe are low
// RQ3 - status mode holds until a new command; page-read code ends it
// RQ4 - status bit 0 gives pass 0 or fail 1 for the current page
// RQ5 - status bit 1 gives previous page result during cache program; the flash model ties bit 1 to 0
// RQ6 - status bit 5 low while array busy; high when all work is done
// RQ7 - status bit 6 shows cache ready; ready_busy_n mirrors it
// RQ8 - status bit 7 is 1 when unprotected, 0 when protected
// RQ9 - status bits 2 to 4 always read zero
// RQ10 - enhanced status: command then three row cycles, allowed while busy
// RQ11 - enhanced status bits 6,5 shared; bits 1,0 per addressed plane
// RQ12 - enhanced status mode holds; read-mode code before array data output
// RQ13 - host selects output plane cache only by two-plane random read, ready
// RQ14 - host never issues enhanced status in one-time-programmable mode
// RQ15 - unique-ID page holds 16 ID bytes plus complement, sixteen copies
// RQ16 - host validates an ID copy by xor with complement, all ones
// RQ17 - host programs pages in a block in ascending order only
// RQ18 - at most four partial programs per page, no bit programmed twice
// RQ19 - program: data-input code, five address cycles, data, confirm code
// RQ20 - while programming only status and reset commands are issued
// RQ21 - random data input with new column allowed before confirm
// RQ22 - cache confirm drops busy, copies cache to data register, releases; the flash model holds busy for the whole program time
// RQ23 - later cache passes wait for the previous array program
package nsp_pkg;
  localparam logic [7:0] NSP_CMD_READ_MODE  = 8'h00;
  localparam logic [7:0] NSP_CMD_PROG_CONF  = 8'h10;
  localparam logic [7:0] NSP_CMD_CACHE_CONF = 8'h15;
  localparam logic [7:0] NSP_CMD_STATUS     = 8'h70;
  localparam logic [7:0] NSP_CMD_STATUS_ENH = 8'h78;
  localparam logic [7:0] NSP_CMD_DATA_IN    = 8'h80;
  localparam logic [7:0] NSP_CMD_RAND_IN    = 8'h85;
  localparam logic [7:0] NSP_CMD_UNIQUE_ID  = 8'hed;
  localparam logic [7:0] NSP_CMD_RESET      = 8'hff;
  // status byte bit positions
  localparam int NSP_SR_FAIL      = 0;
  localparam int NSP_SR_FAIL_PREV = 1;
  localparam int NSP_SR_ARRAY_RDY = 5;
  localparam int NSP_SR_CACHE_RDY = 6;
  localparam int NSP_SR_UNPROT    = 7;
  // software register addresses (4-bit)
  localparam logic [3:0] NSP_A_CTRL   = 4'h0;
  localparam logic [3:0] NSP_A_CMD    = 4'h1;
  localparam logic [3:0] NSP_A_ADDR   = 4'h2;
  localparam logic [3:0] NSP_A_WDATA  = 4'h3;
  localparam logic [3:0] NSP_A_RDATA  = 4'h4;
  localparam logic [3:0] NSP_A_STATUS = 4'h5;
  localparam logic [3:0] NSP_A_LAST   = 4'h6;
  // pin timing: each write strobe low phase lasts this many clocks
  localparam int NSP_PHASE_NS  = 50;
  localparam int NSP_CLK_NS    = 50;
  localparam int NSP_PHASE_CYC =
    (NSP_PHASE_NS + NSP_CLK_NS - 1) / NSP_CLK_NS;
  localparam logic [1:0] NSP_PHASE_MAX = 2'(NSP_PHASE_CYC);
  // read strobe stays low until the synced byte has settled
  localparam logic [1:0] NSP_RD_LAST   = 2'h3;
  // address cycles that follow each command code
  localparam logic [2:0] NSP_ADDR_PROG = 3'h5;
  localparam logic [2:0] NSP_ADDR_COL  = 3'h2;
  localparam logic [2:0] NSP_ADDR_ROW  = 3'h3;
  localparam logic [7:0] NSP_RST_CTRL = 8'h01;
  typedef enum logic [3:0]
  {
    NSP_IDLE  = 4'b0001,
    NSP_WLOW  = 4'b0010,
    NSP_WHIGH = 4'b0100,
    NSP_RLOW  = 4'b1000
  } nsp_state_e;
endpackage

// File: tb/nsp_flash_model.sv
// behavioural flash device: status modes and page program
// assumes the bench resolves the shared io wire
`timescale 1ns/1ps
`default_nettype none
module nsp_flash_model
#(
  parameter int PROG_NS = 20000
)
(
  input  wire logic       i_ce_n,
  input  wire logic       i_cle,
  input  wire logic       i_ale,
  input  wire logic       i_we_n,
  input  wire logic       i_read_strobe_n,
  input  wire logic       i_wp_n,
  input  wire logic       i_fail,
  input  wire logic [7:0] i_io,
  output logic      [7:0] o_io,
  output logic            o_ready_busy_n
);
  logic [7:0] data_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic       mode_q = 1'b0;
  logic       fail_q = 1'b0;
  logic       rb_q   = 1'b1;
  // no cache pass modelled, so array and cache ready coincide
  wire  [7:0] stat_w = {i_wp_n, rb_q, rb_q, 3'b000, 1'b0, fail_q};
  assign o_ready_busy_n = rb_q;
  // released bus shows the inverse, so a stale byte never passes
  assign o_io = (!i_ce_n && !i_read_strobe_n) ?
    (mode_q ? stat_w : data_q) : ~last_q;
  always @(posedge i_read_strobe_n) last_q = mode_q ? stat_w : data_q;
  always @(posedge i_we_n)
    if (!i_ce_n && i_cle && (rb_q || i_io inside {8'h70, 8'h78, 8'hff}))
    begin
      mode_q = i_io == 8'h70 || i_io == 8'h78;
      // either confirm code holds busy for the whole program time
      if (i_io == 8'h10 || i_io == 8'h15)
        fork
          begin
            rb_q = 1'b0;
            #(PROG_NS);
            fail_q = i_fail;
            rb_q = 1'b1;
          end
        join_none
    end
    else if (!i_ce_n && !i_ale && !i_cle)
      data_q = i_io;
endmodule
`default_nettype wire

// File: tb/nsp_properties.sv
// pin and port checks for the nand host controller
// assumes a bind onto nsp_host and its single clock
`timescale 1ns/1ps
`default_nettype none
module nsp_properties
(
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       o_ce_n,
  input wire logic       o_cle,
  input wire logic       o_ale,
  input wire logic       o_we_n,
  input wire logic       o_read_strobe_n,
  input wire logic       o_wp_n,
  input wire logic       o_io_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence re_held;
    !o_read_strobe_n [*3] ##1 o_read_strobe_n;
  endsequence
  sequence cmd_latch;
    !o_we_n && !o_ce_n && o_io_oe ##1 o_we_n && o_cle;
  endsequence
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its slot");
  we_pulse_a: assert property ($fell(o_we_n) |=> $rose(o_we_n))
    else $error("write strobe not one cycle");
  latch_excl_a: assert property (!(o_cle && o_ale))
    else $error("command and address latch together");
  we_drive_a: assert property (!o_we_n |-> !o_ce_n && o_io_oe)
    else $error("write strobe without select or drive");
  re_pulse_a: assert property ($fell(o_read_strobe_n) |-> re_held)
    else $error("read strobe length wrong");
  re_quiet_a: assert property (!o_read_strobe_n |-> !o_io_oe && o_we_n)
    else $error("bus driven during read");
  wp_hold_a: assert property (!$past(i_wr) && !$past(i_wr, 2)
    |-> $stable(o_wp_n))
    else $error("protect pin moved without write");
  cmd_start_a: assert property ($rose(o_cle) |-> cmd_latch)
    else $error("command cycle malformed");
endmodule
bind nsp_host nsp_properties u_props (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_ce_n(o_ce_n),
  .o_cle(o_cle), .o_ale(o_ale), .o_we_n(o_we_n), .o_wp_n(o_wp_n),
  .o_read_strobe_n(o_read_strobe_n), .o_io_oe(o_io_oe));
`default_nettype wire

// File: tb/test_nand_status_and_program.sv
// self-checking bench for the nand status and program host
// assumes the flash model on the far side, 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
module test_nand_status_and_program
  import nsp_pkg::*;
;
  logic       i_clk   = 1'b0;
  logic       i_rstn  = 1'b0;
  logic [3:0] i_addr  = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr    = 1'b0;
  logic       i_rd    = 1'b0;
  logic       fail    = 1'b0;
  logic [7:0] o_rdata, io_out, dev_io, v;
  logic       ce_n, cle, ale, we_n, re_n, wp_n, oe, rb_n;
  wire  [7:0] io_w = oe ? io_out : dev_io;
  int         err_total = 0;
  int         tests_run = 0;
  always #25 i_clk = ~i_clk;
  nsp_host DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_ce_n(ce_n), .o_cle(cle), .o_ale(ale), .o_we_n(we_n),
    .o_read_strobe_n(re_n), .o_wp_n(wp_n), .o_io_out(io_out),
    .o_io_oe(oe), .i_io_in(io_w), .i_ready_busy_n(rb_n));
  nsp_flash_model dev (.i_ce_n(ce_n), .i_cle(cle), .i_ale(ale),
    .i_we_n(we_n), .i_read_strobe_n(re_n), .i_wp_n(wp_n), .i_fail(fail),
    .i_io(io_w), .o_io(dev_io), .o_ready_busy_n(rb_n));
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // bounded wait on one status bit; a hang counts as a mismatch
  task automatic poll(input int b, input logic lvl);
    logic [7:0] s;
    s = ~{8{lvl}};
    for (int n = 0; n < 1000 && s[b] !== lvl; n++)
      rd(NSP_A_STATUS, s);
    chk({7'h00, s[b]}, {7'h00, lvl});
  endtask
  task automatic op(input logic [3:0] a, input logic [7:0] d);
    poll(0, 1'b0);
    wr(a, d);
  endtask
  task automatic get(input logic [3:0] a, output logic [7:0] d);
    poll(0, 1'b0);
    rd(a, d);
  endtask
  // first read runs the pin cycle, second returns its byte
  task automatic fetch(output logic [7:0] d);
    get(NSP_A_RDATA, d);
    get(NSP_A_RDATA, d);
  endtask
  initial
  begin
    #500_000;
    err_total++;
    complete_run();
  end
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(NSP_A_CTRL, v);
    chk(v, NSP_RST_CTRL);
    rd(4'hf, v);
    chk(v, 8'h00);
    op(NSP_A_CTRL, 8'h03);
    op(NSP_A_CMD, NSP_CMD_STATUS);
    fetch(v);
    chk(v, 8'he0);
    fail <= 1'b1;
    op(NSP_A_CMD, NSP_CMD_DATA_IN);
    poll(3, 1'b1);
    repeat (5) op(NSP_A_ADDR, 8'h00);
    poll(3, 1'b0);
    op(NSP_A_WDATA, 8'h3c);
    op(NSP_A_CMD, NSP_CMD_RAND_IN);
    poll(3, 1'b1);
    repeat (2) op(NSP_A_ADDR, 8'h04);
    op(NSP_A_WDATA, 8'h5a);
    op(NSP_A_CMD, NSP_CMD_PROG_CONF);
    op(NSP_A_CMD, NSP_CMD_STATUS);
    fetch(v);
    chk(v, 8'h80);
    op(NSP_A_CMD, NSP_CMD_READ_MODE);
    get(NSP_A_LAST, v);
    chk(v, NSP_CMD_STATUS);
    poll(1, 1'b1);
    fetch(v);
    chk(v, 8'he1);
    op(NSP_A_CMD, NSP_CMD_READ_MODE);
    fetch(v);
    chk(v, 8'h5a);
    op(NSP_A_CTRL, 8'h01);
    op(NSP_A_CMD, NSP_CMD_STATUS_ENH);
    repeat (3) op(NSP_A_ADDR, 8'h00);
    poll(3, 1'b0);
    fetch(v);
    chk(v, 8'h61);
    op(NSP_A_CMD, NSP_CMD_DATA_IN);
    repeat (5) op(NSP_A_ADDR, 8'h01);
    op(NSP_A_WDATA, 8'h96);
    op(NSP_A_CMD, NSP_CMD_CACHE_CONF);
    poll(1, 1'b0);
    poll(1, 1'b1);
    op(NSP_A_CMD, NSP_CMD_STATUS);
    fetch(v);
    chk(v, 8'h61);
    complete_run();
  end
endmodule
`default_nettype wire
